// file: logic/irq_event_detect.sv
// pin synchronisers, edge and change detection, timer wrap detection
// assumes pins are asynchronous and the timer count is on ref_clk
`timescale 1ns/100ps
module irq_event_detect (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ext_irq_pin,
  input wire logic [3:0] port_b_pins,
  input wire logic [7:0] timer_zero_count,
  irq_event_if.detect ev
);
  typedef struct packed {
    logic ext_s1;
    logic ext_s2;
    logic ext_prev;
    logic [3:0] port_s1;
    logic [3:0] port_s2;
    logic [3:0] port_ref;
    logic [7:0] tmr_prev;
    logic ext_evt;
    logic port_evt;
    logic tmr_evt;
  } det_state_t;

  det_state_t st_ff;
  det_state_t nxt_st;

  // two flops before any logic looks at a pin
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ext_s1 = ext_irq_pin;
    nxt_st.ext_s2 = st_ff.ext_s1;
    nxt_st.port_s1 = port_b_pins;
    nxt_st.port_s2 = st_ff.port_s1;
    nxt_st.ext_prev = st_ff.ext_s2;
    nxt_st.tmr_prev = timer_zero_count;
    // edge polarity follows the edge select option bit
    nxt_st.ext_evt = ev.ext_edge_select ?
      (st_ff.ext_s2 & ~st_ff.ext_prev) :
      (~st_ff.ext_s2 & st_ff.ext_prev);
    // a read reloads the reference, so a change landing then is lost
    if (ev.port_read) begin
      nxt_st.port_ref = st_ff.port_s2;
    end
    nxt_st.port_evt = (st_ff.port_s2 != st_ff.port_ref) &&
      !ev.port_read;
    nxt_st.tmr_evt = (st_ff.tmr_prev == irq_pkg::TMR_ALL_ONES) &&
      (timer_zero_count == irq_pkg::TMR_ZERO);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ev.ext_evt = st_ff.ext_evt;
  assign ev.port_evt = st_ff.port_evt;
  assign ev.tmr_evt = st_ff.tmr_evt;

  AST_EXT_RISE: assert property (@(posedge ref_clk) disable iff (rst)
    ($rose(ext_irq_pin) && ev.ext_edge_select) ##1
    (ext_irq_pin && ev.ext_edge_select) [*2] |=> ev.ext_evt)
    else $error("rising pin edge not detected");
  AST_EXT_FALL: assert property (@(posedge ref_clk) disable iff (rst)
    ($fell(ext_irq_pin) && !ev.ext_edge_select) ##1
    (!ext_irq_pin && !ev.ext_edge_select) [*2] |=> ev.ext_evt)
    else $error("falling pin edge not detected");
  AST_TMR_WRAP: assert property (@(posedge ref_clk) disable iff (rst)
    (timer_zero_count == 8'h00 && $past(timer_zero_count) == 8'hff)
    |=> ev.tmr_evt)
    else $error("timer wrap not detected");
endmodule // irq_event_detect

// file: logic/irq_event_if.sv
// event wires between the pin detector and the interrupt controller
// assumes both ends run on ref_clk
`timescale 1ns/100ps
interface irq_event_if;
  logic ext_edge_select;
  logic port_read;
  logic ext_evt;
  logic port_evt;
  logic tmr_evt;
  modport detect (
    input ext_edge_select,
    input port_read,
    output ext_evt,
    output port_evt,
    output tmr_evt
  );
  modport ctrl (
    output ext_edge_select,
    output port_read,
    input ext_evt,
    input port_evt,
    input tmr_evt
  );
endinterface

// file: logic/irq_flag_vector.sv
// interrupt flags, enables, request gating and the take sequence
// assumes the core gives a return pc, a return pulse and a sleep level
`timescale 1ns/100ps
module irq_flag_vector (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ext_irq_pin,
  input wire logic [3:0] port_b_pins,
  input wire logic port_b_read,
  input wire logic [7:0] timer_zero_count,
  input wire logic [7:0] periph_evt_a,
  input wire logic [7:0] periph_evt_b,
  input wire logic [12:0] return_pc,
  input wire logic return_from_irq_instr,
  input wire logic sleep_active,
  output logic irq_ack,
  output logic stack_push,
  output logic [12:0] stack_push_addr,
  output logic pc_load,
  output logic [12:0] pc_load_addr,
  output logic core_wake
);
  typedef struct packed {
    logic [7:0] intctl;
    logic [7:0] pflag_a;
    logic [7:0] pflag_b;
    logic [7:0] pen_a;
    logic [7:0] pen_b;
    logic edge_sel;
    logic [1:0] qph;
    irq_pkg::seq_state_t seq;
    logic in_service;
    logic [12:0] ret_pc;
    logic [12:0] load_addr;
    logic [7:0] rdata;
    logic ack;
    logic push;
    logic load;
    logic wake;
  } ctl_state_t;

  ctl_state_t st_ff;
  ctl_state_t nxt_st;
  irq_event_if ev_if ();

  logic global_irq_enable;
  logic core_pend;
  logic per_pend;
  logic pend_raw;
  logic irq_req;
  logic boundary;
  logic take;

  irq_event_detect u_detect (
    .ref_clk(ref_clk),
    .rst(rst),
    .ext_irq_pin(ext_irq_pin),
    .port_b_pins(port_b_pins),
    .timer_zero_count(timer_zero_count),
    .ev(ev_if.ctrl)
  );

  assign ev_if.ext_edge_select = st_ff.edge_sel;
  assign ev_if.port_read = port_b_read;

  // register read mux, used only for the registered read data
  function automatic logic [7:0] read_mux(
    input logic [2:0] addr,
    input ctl_state_t s,
    input logic req
  );
    logic [7:0] v;
    v = 8'h00;
    if (addr == irq_pkg::INTCTL_OFS) begin
      v = s.intctl;
    end else if (addr == irq_pkg::PFLAG_A_OFS) begin
      v = s.pflag_a;
    end else if (addr == irq_pkg::PFLAG_B_OFS) begin
      v = s.pflag_b;
    end else if (addr == irq_pkg::PEN_A_OFS) begin
      v = s.pen_a;
    end else if (addr == irq_pkg::PEN_B_OFS) begin
      v = s.pen_b;
    end else if (addr == irq_pkg::OPTION_OFS) begin
      v[irq_pkg::EDGE_SEL_BIT] = s.edge_sel;
    end else if (addr == irq_pkg::STATUS_OFS) begin
      v = {3'h0, s.wake, s.seq, req, s.in_service};
    end
    return v;
  endfunction

  // request: or of flag and enable, peripherals behind the group enable
  assign global_irq_enable = st_ff.intctl[irq_pkg::GIE_BIT];
  assign core_pend =
    (st_ff.intctl[irq_pkg::TIMER_ZERO_OVERFLOW_FLAG_BIT] & st_ff.intctl[irq_pkg::TIMER_ZERO_OVERFLOW_ENABLE_BIT]) |
    (st_ff.intctl[irq_pkg::EXT_PIN_FLAG_BIT] & st_ff.intctl[irq_pkg::EXT_PIN_ENABLE_BIT]) |
    (st_ff.intctl[irq_pkg::PORT_CHANGE_FLAG_BIT] &
     st_ff.intctl[irq_pkg::PORT_CHANGE_ENABLE_BIT]);
  assign per_pend = st_ff.intctl[irq_pkg::PEIE_BIT] &
    (|(st_ff.pflag_a & st_ff.pen_a) |
     |(st_ff.pflag_b & st_ff.pen_b));
  assign pend_raw = core_pend | per_pend;
  assign irq_req = global_irq_enable & pend_raw;
  // no priority among sources; software polls the flags to find them
  assign boundary = (st_ff.qph == irq_pkg::Q_LAST);
  // sleeping core fetches nothing, so the take waits for the wake
  assign take = irq_req && boundary && (st_ff.seq == irq_pkg::SEQ_IDLE) &&
    !sleep_active;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.qph = st_ff.qph + 2'h1;
    nxt_st.ack = 1'b0;
    nxt_st.push = 1'b0;
    nxt_st.load = 1'b0;
    // software writes first, so hardware sets below win over a clear
    if (reg_wr) begin
      if (reg_addr == irq_pkg::INTCTL_OFS) begin
        nxt_st.intctl = reg_wdata;
      end else if (reg_addr == irq_pkg::PFLAG_A_OFS) begin
        nxt_st.pflag_a = reg_wdata;
      end else if (reg_addr == irq_pkg::PFLAG_B_OFS) begin
        nxt_st.pflag_b = reg_wdata;
      end else if (reg_addr == irq_pkg::PEN_A_OFS) begin
        nxt_st.pen_a = reg_wdata;
      end else if (reg_addr == irq_pkg::PEN_B_OFS) begin
        nxt_st.pen_b = reg_wdata;
      end else if (reg_addr == irq_pkg::OPTION_OFS) begin
        nxt_st.edge_sel = reg_wdata[irq_pkg::EDGE_SEL_BIT];
      end
    end
    // flags set on their events whatever the enables say
    if (ev_if.ext_evt) begin
      nxt_st.intctl[irq_pkg::EXT_PIN_FLAG_BIT] = 1'b1;
    end
    if (ev_if.tmr_evt) begin
      nxt_st.intctl[irq_pkg::TIMER_ZERO_OVERFLOW_FLAG_BIT] = 1'b1;
    end
    if (ev_if.port_evt) begin
      nxt_st.intctl[irq_pkg::PORT_CHANGE_FLAG_BIT] = 1'b1;
    end
    nxt_st.pflag_a = nxt_st.pflag_a | periph_evt_a;
    nxt_st.pflag_b = nxt_st.pflag_b | periph_evt_b;
    // return re-enables; a flag left set re-enters straight away
    if (return_from_irq_instr) begin
      nxt_st.intctl[irq_pkg::GIE_BIT] = 1'b1;
      nxt_st.in_service = 1'b0;
    end
    // wake does not look at the global enable
    nxt_st.wake = sleep_active & pend_raw;
    // take sequence, one instruction cycle per state
    case (st_ff.seq)
      irq_pkg::SEQ_IDLE: begin
        if (take) begin
          nxt_st.intctl[irq_pkg::GIE_BIT] = 1'b0;
          nxt_st.ack = 1'b1;
          nxt_st.in_service = 1'b1;
          nxt_st.ret_pc = return_pc;
          nxt_st.seq = irq_pkg::SEQ_ACK;
        end
      end
      irq_pkg::SEQ_ACK: begin
        if (boundary) begin
          nxt_st.push = 1'b1;
          nxt_st.seq = irq_pkg::SEQ_BR1;
        end
      end
      irq_pkg::SEQ_BR1: begin
        if (boundary) begin
          nxt_st.seq = irq_pkg::SEQ_BR2;
        end
      end
      irq_pkg::SEQ_BR2: begin
        if (boundary) begin
          nxt_st.load = 1'b1;
          nxt_st.load_addr = irq_pkg::IRQ_VECTOR;
          nxt_st.seq = irq_pkg::SEQ_IDLE;
        end
      end
      default: begin
        nxt_st.seq = irq_pkg::SEQ_IDLE;
      end
    endcase
    // read data stand for one cycle only
    nxt_st.rdata = reg_rd ? read_mux(reg_addr, st_ff, irq_req) : 8'h00;
  end

  // every reset clears the global enable along with all flags
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.intctl <= irq_pkg::INTCTL_RST;
      st_ff.pflag_a <= irq_pkg::PREG_RST;
      st_ff.pflag_b <= irq_pkg::PREG_RST;
      st_ff.pen_a <= irq_pkg::PREG_RST;
      st_ff.pen_b <= irq_pkg::PREG_RST;
      st_ff.edge_sel <= irq_pkg::EDGE_SEL_RST;
      st_ff.seq <= irq_pkg::SEQ_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign irq_ack = st_ff.ack;
  assign stack_push = st_ff.push;
  assign stack_push_addr = st_ff.ret_pc;
  assign pc_load = st_ff.load;
  assign pc_load_addr = st_ff.load_addr;
  assign core_wake = st_ff.wake;

  AST_FLAG_NO_MASK: assert property (@(posedge ref_clk) disable iff (rst)
    ev_if.ext_evt && !reg_wr |=> st_ff.intctl[1])
    else $error("pin flag not set on event");
  AST_GIE_BLOCKS: assert property (@(posedge ref_clk) disable iff (rst)
    !global_irq_enable |=> !irq_ack)
    else $error("interrupt taken with global enable clear");
  AST_TAKE_NOW: assert property (@(posedge ref_clk) disable iff (rst)
    irq_req && boundary && st_ff.seq == irq_pkg::SEQ_IDLE && !sleep_active
    |=> irq_ack)
    else $error("enabled request not taken at boundary");
  AST_RESET_GIE: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(rst) |-> !global_irq_enable && !irq_ack)
    else $error("global enable set after reset");
  AST_RETURN_GIE: assert property (@(posedge ref_clk) disable iff (rst)
    return_from_irq_instr && !global_irq_enable |=> global_irq_enable)
    else $error("return did not set global enable");
  AST_PEIE_GATE: assert property (@(posedge ref_clk) disable iff (rst)
    !st_ff.intctl[6] && !core_pend |-> !irq_req && !pend_raw)
    else $error("peripheral request passed a clear group enable");
  AST_TAKE_CLEARS: assert property (@(posedge ref_clk) disable iff (rst)
    irq_ack |-> !global_irq_enable ##4 stack_push)
    else $error("take did not clear enable and push");
  AST_VECTOR: assert property (@(posedge ref_clk) disable iff (rst)
    irq_ack |-> ##12 (pc_load && pc_load_addr == 13'h0004))
    else $error("vector not loaded twelve clocks after take");
  AST_PUSH_PC: assert property (@(posedge ref_clk) disable iff (rst)
    irq_ack |-> ##4 (stack_push_addr == $past(return_pc, 5)))
    else $error("pushed address is not the return pc");
  AST_TMR_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
    ev_if.tmr_evt |=> st_ff.intctl[2])
    else $error("timer flag not set on wrap");
  AST_PORT_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
    ev_if.port_evt |=> st_ff.intctl[0])
    else $error("port change flag not set");
  AST_WAKE: assert property (@(posedge ref_clk) disable iff (rst)
    sleep_active && st_ff.intctl[1] && st_ff.intctl[4] |=> core_wake)
    else $error("pin interrupt did not wake core");
  AST_SLEEP_INLINE: assert property (@(posedge ref_clk) disable iff (rst)
    sleep_active |=> !irq_ack)
    else $error("vectored while still asleep");
  AST_READ_DATA: assert property (@(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == 3'h0 && !reg_wr |=>
    reg_rdata == $past(st_ff.intctl))
    else $error("read data wrong");


  // take sequence shape: every pulse of the sequence lasts one cycle,
  // so a core that counts pulses never sees a take twice
  AST_ACK_ONE: assert property (@(posedge ref_clk) disable iff (rst)
    irq_ack |=> !irq_ack)
    else $error("acknowledge longer than one cycle");

  AST_PUSH_ONE: assert property (@(posedge ref_clk) disable iff (rst)
    stack_push |=> !stack_push)
    else $error("push longer than one cycle");

  AST_LOAD_ONE: assert property (@(posedge ref_clk) disable iff (rst)
    pc_load |=> !pc_load)
    else $error("vector load longer than one cycle");

  // the load always carries the fixed vector, never a stale address
  AST_LOAD_ADDR: assert property (@(posedge ref_clk) disable iff (rst)
    pc_load |-> pc_load_addr == irq_pkg::IRQ_VECTOR)
    else $error("vector load with wrong address");

  // a busy sequence refuses a second take until the load is done
  AST_BUSY_NO_ACK: assert property (@(posedge ref_clk) disable iff (rst)
    st_ff.seq != irq_pkg::SEQ_IDLE |=> !irq_ack)
    else $error("second take while sequence busy");

  AST_IN_SERVICE: assert property (@(posedge ref_clk) disable iff (rst)
    irq_ack |-> st_ff.in_service)
    else $error("take without in service mark");

  // the pushed address changes only with a take
  AST_PUSH_KEEP: assert property (@(posedge ref_clk) disable iff (rst)
    !irq_ack |-> $stable(stack_push_addr))
    else $error("pushed address moved without a take");

  // peripheral pulses land in their flags even with enables off
  AST_PERIPH_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
    periph_evt_a != 8'h00 |=>
    (st_ff.pflag_a & $past(periph_evt_a)) == $past(periph_evt_a))
    else $error("peripheral flag not set on event");

  // wake ignores the global enable; only the vectoring depends on it
  AST_WAKE_NO_GIE: assert property (@(posedge ref_clk) disable iff (rst)
    sleep_active && pend_raw && !global_irq_enable |=> core_wake)
    else $error("wake blocked by clear global enable");

  // a port read cycle never reports a change; that change is lost
  AST_READ_LOSES: assert property (@(posedge ref_clk) disable iff (rst)
    ev_if.port_read |=> !ev_if.port_evt)
    else $error("change reported during port read");

  // return ends the service mark unless a new take lands at once
  AST_RET_CLEARS: assert property (@(posedge ref_clk) disable iff (rst)
    return_from_irq_instr && !take |=> !st_ff.in_service)
    else $error("return left the service mark set");

  COV_TAKE: cover property (@(posedge ref_clk) disable iff (rst)
    irq_ack ##12 pc_load);
  COV_PERIPH_TAKE: cover property (@(posedge ref_clk) disable iff (rst)
    per_pend && !core_pend && global_irq_enable ##[1:8] irq_ack);
  COV_WAKE_VECTOR: cover property (@(posedge ref_clk) disable iff (rst)
    core_wake && global_irq_enable ##[1:40] irq_ack);
  COV_RETURN: cover property (@(posedge ref_clk) disable iff (rst)
    pc_load ##[1:100] return_from_irq_instr);
  COV_SET_BEATS_CLEAR: cover property (@(posedge ref_clk) disable iff (rst)
    reg_wr && reg_addr == 3'h0 && ev_if.ext_evt);
endmodule // irq_flag_vector

// file: logic/irq_pkg.sv
// constants, register map and types of the interrupt flag and vector logic
// assumes one 25 MHz clock and four clocks to one instruction cycle
package irq_pkg;
  // register offsets on the plain register port
  localparam logic [2:0] INTCTL_OFS = 3'h0;
  localparam logic [2:0] PFLAG_A_OFS = 3'h1;
  localparam logic [2:0] PFLAG_B_OFS = 3'h2;
  localparam logic [2:0] PEN_A_OFS = 3'h3;
  localparam logic [2:0] PEN_B_OFS = 3'h4;
  localparam logic [2:0] OPTION_OFS = 3'h5;
  localparam logic [2:0] STATUS_OFS = 3'h6;
  // interrupt_control and option field positions
  localparam int GIE_BIT = 7;
  localparam int PEIE_BIT = 6;
  localparam int TIMER_ZERO_OVERFLOW_ENABLE_BIT = 5;
  localparam int EXT_PIN_ENABLE_BIT = 4;
  localparam int PORT_CHANGE_ENABLE_BIT = 3;
  localparam int TIMER_ZERO_OVERFLOW_FLAG_BIT = 2;
  localparam int EXT_PIN_FLAG_BIT = 1;
  localparam int PORT_CHANGE_FLAG_BIT = 0;
  localparam int EDGE_SEL_BIT = 6;
  // reset values
  localparam logic [7:0] INTCTL_RST = 8'h00;
  localparam logic [7:0] PREG_RST = 8'h00;
  localparam logic EDGE_SEL_RST = 1'b1;
  // vector and timing
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [7:0] TMR_ALL_ONES = 8'hff;
  localparam logic [7:0] TMR_ZERO = 8'h00;
  // gray coded take sequence: acknowledge, then two branch cycles
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_ACK = 2'h1,
    SEQ_BR1 = 2'h3,
    SEQ_BR2 = 2'h2
  } seq_state_t;
endpackage

// file: testbench/irq_core_model.sv
// core-side model: supplies the return address and the return instruction
// assumes the take sequence pulses stack_push and then pc_load on ref_clk
`timescale 1ns/100ps
module irq_core_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic stack_push,
  input wire logic pc_load,
  input wire logic svc_done,
  output logic [12:0] return_pc,
  output logic return_from_irq_instr
);
  logic in_isr;
  // return only after the vector load and once the routine says it is done
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      return_pc <= 13'h0123;
      return_from_irq_instr <= 1'b0;
      in_isr <= 1'b0;
    end else begin
      return_from_irq_instr <= 1'b0;
      // pc moves on only after the push, so the pushed value stays stable
      if (stack_push) return_pc <= return_pc + 13'h0011;
      if (pc_load) in_isr <= 1'b1;
      if (svc_done && in_isr) begin
        return_from_irq_instr <= 1'b1;
        in_isr <= 1'b0;
      end
    end
  end
endmodule // irq_core_model

// file: testbench/tb.sv
// self-checking bench for the interrupt flag and vector logic
// assumes the core model answers returns; one 25 MHz clock
`timescale 1ns/100ps
module tb;
  logic ref_clk, rst, reg_wr, reg_rd, ext_irq_pin, port_b_read;
  logic sleep_active, svc_done, return_from_irq_instr;
  logic irq_ack, stack_push, pc_load, core_wake;
  logic [2:0] reg_addr;
  logic [3:0] port_b_pins;
  logic [7:0] reg_wdata, reg_rdata, timer_zero_count, periph_evt_a;
  logic [7:0] periph_evt_b, d;
  logic [12:0] return_pc, stack_push_addr, pc_load_addr;
  int errors, compares, acks, n;

  irq_flag_vector u_dut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .ext_irq_pin, .port_b_pins, .port_b_read,
    .timer_zero_count, .periph_evt_a, .periph_evt_b, .return_pc,
    .return_from_irq_instr, .sleep_active, .irq_ack, .stack_push,
    .stack_push_addr, .pc_load, .pc_load_addr, .core_wake);
  irq_core_model u_core (.ref_clk, .rst, .stack_push, .pc_load, .svc_done,
    .return_pc, .return_from_irq_instr);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // count takes so a missing or repeated take shows up
  always @(posedge ref_clk) begin
    if (irq_ack === 1'b1) acks <= acks + 1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic pulse_read();
    @(posedge ref_clk);
    port_b_read <= 1'b1;
    @(posedge ref_clk);
    port_b_read <= 1'b0;
  endtask
  // waits for the take; the bound is four instruction cycles
  task automatic wait_ack();
    n = 0;
    while (irq_ack !== 1'b1 && n < 30) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(n <= 16, 1'b1);
  endtask
  // push and vector load follow the acknowledge at fixed distances
  task automatic seq_check();
    logic [12:0] pc;
    pc = return_pc;
    repeat (4) @(posedge ref_clk);
    #1;
    check(stack_push, 1'b1);
    check(stack_push_addr, pc);
    repeat (8) @(posedge ref_clk);
    #1;
    check(pc_load, 1'b1);
    check(pc_load_addr, 13'h0004);
  endtask
  task automatic serve();
    @(posedge ref_clk);
    svc_done <= 1'b1;
    @(posedge ref_clk);
    svc_done <= 1'b0;
    tick(2);
  endtask

  task automatic t_reset();
    rd(3'h0);
    check(d, 8'h00);
    rd(3'h5);
    check(d, 8'h40);
    for (int a = 1; a < 5; a++) begin
      rd(a[2:0]);
      check(d, 8'h00);
    end
    wr(3'h7, 8'hff);
    wr(3'h6, 8'hff);
    rd(3'h7);
    check(d, 8'h00);
    rd(3'h6);
    check(d, 8'h00);
  endtask

  // flags set with every enable off while gie is set: nothing is taken
  task automatic t_flags();
    int a0;
    a0 = acks;
    wr(3'h0, 8'h80);
    @(posedge ref_clk);
    timer_zero_count <= 8'hff;
    @(posedge ref_clk);
    timer_zero_count <= 8'h00;
    tick(4);
    rd(3'h0);
    check(d, 8'h84);
    ext_irq_pin <= 1'b1;
    tick(8);
    rd(3'h0);
    check(d, 8'h86);
    port_b_pins <= 4'h5;
    tick(8);
    rd(3'h0);
    check(d, 8'h87);
    periph_evt_a <= 8'h21;
    periph_evt_b <= 8'h80;
    @(posedge ref_clk);
    periph_evt_a <= 8'h00;
    periph_evt_b <= 8'h00;
    rd(3'h1);
    check(d, 8'h21);
    rd(3'h2);
    check(d, 8'h80);
    check(acks - a0, 0);
    pulse_read();
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h00);
    ext_irq_pin <= 1'b0;
    tick(8);
    rd(3'h0);
    check(d, 8'h00);
  endtask

  task automatic t_edge();
    wr(3'h5, 8'h00);
    ext_irq_pin <= 1'b1;
    tick(8);
    rd(3'h0);
    check(d, 8'h00);
    ext_irq_pin <= 1'b0;
    tick(8);
    rd(3'h0);
    check(d, 8'h02);
    wr(3'h0, 8'h00);
    wr(3'h5, 8'h40);
  endtask

  // one take per core source: timer, pin, port change
  task automatic t_take();
    logic [7:0] en[3] = '{8'h20, 8'h10, 8'h08};
    logic [7:0] fl[3] = '{8'h04, 8'h02, 8'h01};
    int a0;
    for (int k = 0; k < 3; k++) begin
      a0 = acks;
      wr(3'h0, 8'h80 | en[k]);
      @(posedge ref_clk);
      if (k == 0) timer_zero_count <= 8'hff;
      if (k == 1) ext_irq_pin <= 1'b1;
      if (k == 2) port_b_pins <= port_b_pins ^ 4'h1;
      @(posedge ref_clk);
      if (k == 0) timer_zero_count <= 8'h00;
      wait_ack();
      seq_check();
      rd(3'h0);
      check(d, en[k] | fl[k]);
      if (k == 2) pulse_read();
      wr(3'h0, en[k]);
      serve();
      rd(3'h0);
      check(d, 8'h80 | en[k]);
      check(acks - a0, 1);
      n = 0;
      d = 8'h80;
      while (d[7] !== 1'b0 && n < 4) begin
        wr(3'h0, 8'h00);
        rd(3'h0);
        n++;
      end
      check(d, 8'h00);
    end
    ext_irq_pin <= 1'b0;
  endtask

  // peripheral source needs its group enable on top of gie
  task automatic t_periph();
    int a0;
    a0 = acks;
    wr(3'h3, 8'h02);
    wr(3'h0, 8'h80);
    periph_evt_a <= 8'h02;
    @(posedge ref_clk);
    periph_evt_a <= 8'h00;
    tick(24);
    check(acks - a0, 0);
    wr(3'h0, 8'hc0);
    wait_ack();
    seq_check();
    wr(3'h1, 8'h00);
    serve();
    check(acks - a0, 1);
    wr(3'h0, 8'h00);
    wr(3'h3, 8'h00);
  endtask

  task automatic t_wake();
    int a0;
    a0 = acks;
    wr(3'h0, 8'h10);
    sleep_active <= 1'b1;
    ext_irq_pin <= 1'b1;
    tick(8);
    check(core_wake, 1'b1);
    sleep_active <= 1'b0;
    tick(24);
    check(acks - a0, 0);
    rd(3'h0);
    check(d, 8'h12);
    sleep_active <= 1'b1;
    ext_irq_pin <= 1'b0;
    wr(3'h0, 8'h90);
    ext_irq_pin <= 1'b1;
    tick(8);
    check(core_wake, 1'b1);
    check(acks - a0, 0);
    sleep_active <= 1'b0;
    wait_ack();
    seq_check();
    wr(3'h0, 8'h10);
    serve();
    wr(3'h0, 8'h00);
  endtask

  task automatic end_of_test();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #(40 * 6000);
    errors++;
    end_of_test();
  end

  initial begin
    {reg_wr, reg_rd, ext_irq_pin, port_b_read, sleep_active} = 5'h00;
    {svc_done, reg_addr, port_b_pins, acks} = '0;
    {reg_wdata, timer_zero_count, periph_evt_a, periph_evt_b} = '0;
    errors = 0;
    compares = 0;
    rst = 1'b1;
    tick(16);
    rst <= 1'b0;
    t_reset();
    t_flags();
    t_edge();
    t_take();
    t_periph();
    t_wake();
    end_of_test();
  end
endmodule // tb
